// File: shared/pcfs_pkg.sv
// Package: constants and carriers for the program counter and fast shadow block
package pcfs_pkg;
   localparam int PCFS_PC_W = 21;
   localparam int PCFS_ADDR_W = 4;
   // Register indices on the plain port
   localparam logic [3:0] PCFS_OFF_PCLOW = 4'h0;
   localparam logic [3:0] PCFS_OFF_HLATCH = 4'h1;
   localparam logic [3:0] PCFS_OFF_ULATCH = 4'h2;
   localparam logic [3:0] PCFS_OFF_RETURN_STACK_POINTER = 4'h3;
   localparam logic [3:0] PCFS_OFF_TOPLOW = 4'h4;
   localparam logic [3:0] PCFS_OFF_TOPHIGH = 4'h5;
   localparam logic [3:0] PCFS_OFF_TOPUPPER = 4'h6;
   localparam logic [20:0] PCFS_PC_RESET = 21'h000000;
   localparam logic [7:0] PCFS_HLATCH_RESET = 8'h00;
   localparam logic [4:0] PCFS_ULATCH_RESET = 5'h00;
   localparam logic [20:0] PCFS_VEC_HIGH = 21'h000008;
   localparam logic [20:0] PCFS_VEC_LOW = 21'h000018;
   localparam logic [20:0] PCFS_PC_STEP = 21'h000002;
   localparam int PCFS_STK_DEPTH = 31;

   // Core registers saved by the shadow store
   typedef struct packed {
      logic [7:0] status;
      logic [7:0] working;
      logic [7:0] bank;
   } pcfs_ctx_s;

   // Counter update command from the core sequencer
   typedef enum logic [2:0] {
      PCFS_OP_HOLD = 3'b000,
      PCFS_OP_STEP = 3'b001,
      PCFS_OP_JUMP = 3'b010,
      PCFS_OP_CALL = 3'b011,
      PCFS_OP_RET = 3'b100,
      PCFS_OP_IRQ = 3'b101
   } pcfs_op_e;
endpackage

// File: rtl/pcfs_shadow.sv
// One-deep shadow store for status, working and bank select
`timescale 1ns/1ps
`default_nettype none
module pcfs_shadow
   import pcfs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic save,
   input wire pcfs_ctx_s ctx_in,
   output pcfs_ctx_s ctx_out
);
   pcfs_ctx_s ctx_reg;
   pcfs_ctx_s ctx_next;

   // Only save loads this store from ctx_in; reset clears it and ctx_out reads it
   always_comb begin
      ctx_next = ctx_reg;
      if (save) begin
         ctx_next = ctx_in;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctx_reg <= '0;
      end else begin
         ctx_reg <= ctx_next;
      end
   end

   assign ctx_out = ctx_reg;
endmodule // pcfs_shadow
`default_nettype wire

// File: rtl/pcfs_retstack.sv
// Hardware return-address stack with pointer
`timescale 1ns/1ps
`default_nettype none
module pcfs_retstack
   import pcfs_pkg::*;
#(
   parameter int DEPTH = PCFS_STK_DEPTH
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic push,
   input wire logic pop,
   input wire logic [20:0] push_addr,
   output logic [20:0] top_addr,
   output logic [4:0] ptr
);
   initial begin
      if (DEPTH < 1 || DEPTH > 31) $error("pcfs_retstack: DEPTH 1..31");
   end
   logic [20:0] mem [1:DEPTH];
   logic [4:0] ptr_reg;
   logic [4:0] ptr_next;

   always_comb begin
      ptr_next = ptr_reg;
      if (push && ptr_reg != 5'(DEPTH)) begin
         ptr_next = ptr_reg + 5'h01;
      end else if (pop && ptr_reg != 5'h00) begin
         ptr_next = ptr_reg - 5'h01;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_reg <= 5'h00;
      end else begin
         ptr_reg <= ptr_next;
      end
   end

   always_ff @(posedge mclk) begin
      if (push && ptr_reg != 5'(DEPTH)) begin
         mem[ptr_next] <= push_addr;
      end
   end

   assign top_addr = (ptr_reg == 5'h00) ? 21'h000000 : mem[ptr_reg];
   assign ptr = ptr_reg;
endmodule // pcfs_retstack
`default_nettype wire

// File: rtl/pcfs_core.sv
// Program counter, latch registers, return stack and shadow store
`timescale 1ns/1ps
`default_nettype none
module pcfs_core
   import pcfs_pkg::*;
#(
   parameter int STK_DEPTH = PCFS_STK_DEPTH
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire pcfs_op_e pc_op,
   input wire logic [20:0] pc_target,
   input wire logic fast,
   input wire logic irq_high,
   input wire logic global_high_irq_enable,
   input wire logic global_low_irq_enable,
   input wire pcfs_ctx_s ctx_live,
   output logic ctx_restore,
   output pcfs_ctx_s ctx_restored,
   output logic [20:0] fetch_addr,
   output logic irq_taken
);
   initial begin
      if (STK_DEPTH < 1 || STK_DEPTH > 31) $error("pcfs_core: STK_DEPTH");
   end

   logic [20:0] pc_reg;
   logic [20:0] pc_next;
   logic [7:0] hlatch_reg;
   logic [7:0] hlatch_next;
   logic [4:0] ulatch_reg;
   logic [4:0] ulatch_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic restore_reg;
   logic restore_next;
   logic irq_ok;
   logic push;
   logic pop;
   logic shadow_save;
   logic [20:0] top_addr;
   logic [4:0] stk_ptr;

   // Interrupt honoured only when the matching global enable is set
   assign irq_ok = (pc_op == PCFS_OP_IRQ) &&
      (irq_high ? global_high_irq_enable : global_low_irq_enable);
   assign push = irq_ok || (pc_op == PCFS_OP_CALL);
   assign pop = (pc_op == PCFS_OP_RET);
   // Both priorities share the one entry, so nesting clobbers it
   assign shadow_save = irq_ok || (pc_op == PCFS_OP_CALL && fast);

   always_comb begin
      pc_next = pc_reg;
      hlatch_next = hlatch_reg;
      ulatch_next = ulatch_reg;
      rdata_next = 8'h00;
      restore_next = 1'b0;
      case (pc_op)
         PCFS_OP_STEP: pc_next = pc_reg + PCFS_PC_STEP;
         PCFS_OP_JUMP, PCFS_OP_CALL: pc_next = pc_target;
         PCFS_OP_RET: begin
            pc_next = top_addr;
            restore_next = fast;
         end
         PCFS_OP_IRQ: begin
            if (irq_ok) begin
               pc_next = irq_high ? PCFS_VEC_HIGH : PCFS_VEC_LOW;
            end
         end
         default: pc_next = pc_reg;
      endcase
      // Software write wins over the sequencer for the whole counter
      if (reg_wr) begin
         case (reg_addr)
            PCFS_OFF_PCLOW: begin
               pc_next = {ulatch_reg, hlatch_reg, reg_wdata};
            end
            PCFS_OFF_HLATCH: hlatch_next = reg_wdata;
            PCFS_OFF_ULATCH: ulatch_next = reg_wdata[4:0];
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            PCFS_OFF_PCLOW: begin
               rdata_next = pc_reg[7:0];
               hlatch_next = pc_reg[15:8];
               ulatch_next = pc_reg[20:16];
            end
            PCFS_OFF_HLATCH: rdata_next = hlatch_reg;
            PCFS_OFF_ULATCH: rdata_next = {3'h0, ulatch_reg};
            PCFS_OFF_RETURN_STACK_POINTER: rdata_next = {3'h0, stk_ptr};
            PCFS_OFF_TOPLOW: rdata_next = top_addr[7:0];
            PCFS_OFF_TOPHIGH: rdata_next = top_addr[15:8];
            PCFS_OFF_TOPUPPER: rdata_next = {3'h0, top_addr[20:16]};
            default: rdata_next = 8'h00;
         endcase
      end
      pc_next[0] = 1'b0;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pc_reg <= PCFS_PC_RESET;
         hlatch_reg <= PCFS_HLATCH_RESET;
         ulatch_reg <= PCFS_ULATCH_RESET;
         rdata_reg <= 8'h00;
         restore_reg <= 1'b0;
      end else begin
         pc_reg <= pc_next;
         hlatch_reg <= hlatch_next;
         ulatch_reg <= ulatch_next;
         rdata_reg <= rdata_next;
         restore_reg <= restore_next;
      end
   end

   pcfs_shadow u_shadow (
      .mclk(mclk),
      .rst_n(rst_n),
      .save(shadow_save),
      .ctx_in(ctx_live),
      .ctx_out(ctx_restored)
   );

   pcfs_retstack #(.DEPTH(STK_DEPTH)) u_stack (
      .mclk(mclk),
      .rst_n(rst_n),
      .push(push),
      .pop(pop),
      .push_addr(pc_reg),
      .top_addr(top_addr),
      .ptr(stk_ptr)
   );

   assign reg_rdata = rdata_reg;
   assign fetch_addr = pc_reg;
   assign ctx_restore = restore_reg;
   assign irq_taken = irq_ok;
endmodule // pcfs_core
`default_nettype wire

// File: sim/pcfs_core_asserts.sv
// Checker for the counter, vectors and register port
`timescale 1ns/1ps
`default_nettype none
module pcfs_core_asserts
   import pcfs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire pcfs_op_e pc_op,
   input wire logic [20:0] pc_target,
   input wire logic fast,
   input wire logic irq_high,
   input wire logic global_high_irq_enable,
   input wire logic global_low_irq_enable,
   input wire logic ctx_restore,
   input wire logic [20:0] fetch_addr,
   input wire logic irq_taken
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   rst_clear_a: assert property ($rose(rst_n) |-> fetch_addr == 21'h000000)
      else $error("pc not cleared");
   bit_zero_a: assert property (fetch_addr[0] == 1'b0)
      else $error("pc bit 0 set");
   step_two_a: assert property (pc_op == PCFS_OP_STEP && !reg_wr
      |=> fetch_addr == $past(fetch_addr) + PCFS_PC_STEP)
      else $error("bad step");
   jump_load_a: assert property (pc_op == PCFS_OP_JUMP && !reg_wr
      |=> fetch_addr[20:1] == $past(pc_target[20:1]))
      else $error("bad jump");
   irq_gate_a: assert property (pc_op == PCFS_OP_IRQ |-> irq_taken ==
      (irq_high ? global_high_irq_enable : global_low_irq_enable))
      else $error("bad irq gate");
   vec_load_a: assert property (irq_taken && !reg_wr |=> fetch_addr ==
      ($past(irq_high) ? PCFS_VEC_HIGH : PCFS_VEC_LOW))
      else $error("bad vector");
   fast_ret_a: assert property (pc_op == PCFS_OP_RET && fast
      |=> ctx_restore) else $error("no restore");
   pcl_read_a: assert property (reg_rd && reg_addr == PCFS_OFF_PCLOW
      |=> reg_rdata == $past(fetch_addr[7:0])) else $error("bad pcl");
   pcl_write_a: assert property (reg_wr && reg_addr == PCFS_OFF_PCLOW
      |=> fetch_addr[7:1] == $past(reg_wdata[7:1]))
      else $error("bad pcl write");
   hidden_rd_a: assert property (reg_rd && reg_addr > 4'h6
      |=> reg_rdata == 8'h00) else $error("hidden read");
endmodule // pcfs_core_asserts
bind pcfs_core pcfs_core_asserts chk_u (.*);
`default_nettype wire

// File: sim/pcfs_core_model.sv
// Core register file model feeding the shadow store
`timescale 1ns/1ps
`default_nettype none
module pcfs_core_model
   import pcfs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic set,
   input wire pcfs_ctx_s set_val,
   input wire logic ctx_restore,
   input wire pcfs_ctx_s ctx_restored,
   output var pcfs_ctx_s ctx_live
);
   // Restore wins, a fast return ends the handler's own edits
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctx_live <= '0;
      end else if (ctx_restore) begin
         ctx_live <= ctx_restored;
      end else if (set) begin
         ctx_live <= set_val;
      end
   end
endmodule // pcfs_core_model
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the program counter block
`timescale 1ns/1ps
`default_nettype none
module testbench
   import pcfs_pkg::*;
;
   logic mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic fast = 1'b0, irq_high = 1'b0, set = 1'b0, tk, ctx_restore;
   logic global_high_irq_enable = 1'b0, global_low_irq_enable = 1'b0;
   logic irq_taken;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_v;
   logic [20:0] pc_target = 21'h000000, fetch_addr;
   pcfs_op_e pc_op = PCFS_OP_HOLD;
   pcfs_ctx_s ctx_live, ctx_restored, set_val = '0;
   int bad_count = 0, check_count = 0;
   pcfs_core dut_u (.*);
   pcfs_core_model peer_u (.*);
   initial forever #12.5 mclk = ~mclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
   endtask
   // Irq bits: priority, high enable, low enable
   task automatic op(pcfs_op_e o, logic [20:0] t, logic f, logic [2:0] i);
      @(posedge mclk);
      pc_op <= o;
      pc_target <= t;
      fast <= f;
      {irq_high, global_high_irq_enable, global_low_irq_enable} <= i;
      #1 tk = irq_taken;
      @(posedge mclk);
      pc_op <= PCFS_OP_HOLD;
      #1;
   endtask
   task automatic ctx(input pcfs_ctx_s v);
      @(posedge mclk);
      set <= 1'b1;
      set_val <= v;
      @(posedge mclk);
      set <= 1'b0;
   endtask
   task automatic t_seq;
      chk(fetch_addr, 21'h000000);
      rd(PCFS_OFF_ULATCH);
      chk(rd_v, 8'h00);
      op(PCFS_OP_STEP, 21'h000000, 1'b0, 3'b000);
      chk(fetch_addr, 21'h000002);
      op(PCFS_OP_JUMP, 21'h0ABCDE, 1'b0, 3'b000);
      chk(fetch_addr, 21'h0ABCDE);
      rd(PCFS_OFF_HLATCH);
      chk(rd_v, 8'h00);
   endtask
   task automatic t_latch;
      rd(PCFS_OFF_PCLOW);
      chk(rd_v, 8'hDE);
      rd(PCFS_OFF_HLATCH);
      chk(rd_v, 8'hBC);
      rd(PCFS_OFF_ULATCH);
      chk(rd_v, 8'h0A);
      wr(PCFS_OFF_HLATCH, 8'h12);
      wr(PCFS_OFF_ULATCH, 8'h1F);
      wr(PCFS_OFF_RETURN_STACK_POINTER, 8'h07);
      wr(PCFS_OFF_PCLOW, 8'h35);
      chk(fetch_addr, 21'h1F1234);
   endtask
   // High entry nested in low service clobbers the low save
   task automatic t_irq;
      ctx(24'hA1B2C3);
      op(PCFS_OP_IRQ, 21'h000000, 1'b0, 3'b101);
      chk({tk, fetch_addr}, 22'h1F1234);
      op(PCFS_OP_IRQ, 21'h000000, 1'b0, 3'b001);
      chk({tk, fetch_addr}, {1'b1, PCFS_VEC_LOW});
      rd(PCFS_OFF_RETURN_STACK_POINTER);
      chk(rd_v, 8'h01);
      rd(PCFS_OFF_TOPLOW);
      chk(rd_v, 8'h34);
      rd(PCFS_OFF_TOPHIGH);
      chk(rd_v, 8'h12);
      ctx(24'h0D0E0F);
      op(PCFS_OP_IRQ, 21'h000000, 1'b0, 3'b110);
      chk(fetch_addr, PCFS_VEC_HIGH);
      ctx(24'h555555);
      op(PCFS_OP_RET, 21'h000000, 1'b1, 3'b000);
      chk({ctx_restore, ctx_restored}, 25'h10D0E0F);
      chk(fetch_addr, PCFS_VEC_LOW);
      @(posedge mclk);
      #1 chk(ctx_live, 24'h0D0E0F);
   endtask
   task automatic t_call;
      ctx(24'h123456);
      op(PCFS_OP_CALL, 21'h000100, 1'b1, 3'b000);
      chk(fetch_addr, 21'h000100);
      ctx(24'h000000);
      op(PCFS_OP_RET, 21'h000000, 1'b1, 3'b000);
      chk(ctx_restored, 24'h123456);
      // Plain call must not save, plain return must not restore
      ctx(24'hABCDEF);
      op(PCFS_OP_CALL, 21'h000200, 1'b0, 3'b000);
      op(PCFS_OP_RET, 21'h000000, 1'b0, 3'b000);
      chk({ctx_restore, ctx_restored}, 25'h0123456);
      rd(4'hF);
      chk(rd_v, 8'h00);
   endtask
   task automatic close_out;
      if (bad_count == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      bad_count++;
      close_out;
   end
   initial begin
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      t_seq;
      t_latch;
      t_irq;
      t_call;
      close_out;
   end
endmodule // testbench
`default_nettype wire
